/* File: sbi_consts.svh */
// Offsets, field positions, reset values and counts of the serial bus control
`ifndef SBI_CONSTS_SVH
`define SBI_CONSTS_SVH

// Register indexes; the byte address is four times the index
`define IDX_SBI0      8'h0d
`define IDX_CTRL      8'h10
`define IDX_STATUS    8'h11
`define IDX_IRQ_STAT  8'h12
`define IDX_IRQ_CLR   8'h13
`define IDX_IRQ_EN    8'h14

// Acknowledge and busy control register fields
`define BIT_ACK_TRIG  0
`define BIT_AUTO_ACK  1
`define BIT_ACK_DET   2
`define BIT_BUSY_EN   3

// Own control register fields
`define BIT_CMD_TRIG  0
`define BIT_REL_TRIG  1
`define BIT_WAKEUP    2
`define BIT_SBUS_MODE 3

// Own status register fields
`define BIT_DONE      0
`define BIT_IN_XFER   1
`define BIT_CMD_PEND  2

// Interrupt event positions
`define EV_DONE       0
`define EV_ACK        1

// Reset values
`define RST_SBI0      4'h0
`define RST_IRQ       2'h0

// Bit counter values
`define CNT_IDLE      4'h0
`define CNT_LAST_DATA 4'h7
`define CNT_ACK_SLOT  4'h8
`define CNT_ACK_CLK   4'h9

`endif

/* File: sbi_pkg.sv */
// Types shared by the serial bus acknowledge and busy control
package sbi_pkg;
   typedef logic [3:0] bit_cnt_t;   // Serial clocks seen in a byte
   typedef logic [1:0] irq_vec_t;   // One bit per interrupt event
endpackage : sbi_pkg

/* File: serial_bus_ack_busy_control.sv */
// Acknowledge, busy and trigger control of a two-wire serial channel
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "sbi_consts.svh"
// How it works
// - Completion flag valid once byte finished
// - One-shot trigger drives acknowledge next clock
// - Auto acknowledge on ninth clock or next
// - Auto enable persists; trigger still usable
// - Acknowledge seen on rising edge sets flag
// - Busy after acknowledge in serial bus mode only; stops on the first fall after busy enable is cleared
// - Acknowledge trigger always reads zero
// - Command trigger ignored during transfer
// - Command trigger self-clears, reads zero
// - Release trigger self-clears, reads zero
module serial_bus_ack_busy_control
   import sbi_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Avalon-MM slave
   input  wire logic [9:0]  address_i,
   input  wire logic        read_i,
   input  wire logic        write_i,
   input  wire logic [31:0] writedata_i,
   output logic      [31:0] readdata_o,
   output logic             waitrequest_o,
   // Interrupt
   output logic             irq_o,
   // Two-wire link, open drain data line
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_n_o
);

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   logic scl_s1_q, scl_s2_q, scl_s3_q;  // Clock pin stages
   logic sda_s1_q, sda_s2_q, sda_s3_q;  // Data pin stages

   // Two stages before use, a third for edge finding; idle lines are high
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {scl_s3_q, scl_s2_q, scl_s1_q} <= 3'b111;
         {sda_s3_q, sda_s2_q, sda_s1_q} <= 3'b111;
      end else begin
         {scl_s3_q, scl_s2_q, scl_s1_q} <= {scl_s2_q, scl_s1_q, scl_i};
         {sda_s3_q, sda_s2_q, sda_s1_q} <= {sda_s2_q, sda_s1_q, sda_i};
      end
   end
   logic scl_rise;   // Serial clock rising
   logic scl_fall;   // Serial clock falling
   logic start_det;  // Data falls while clock high
   assign scl_rise  = scl_s2_q & ~scl_s3_q;
   assign scl_fall  = ~scl_s2_q & scl_s3_q;
   assign start_det = scl_s2_q & scl_s3_q & ~sda_s2_q & sda_s3_q;

   ////////////////////////////////////////////////////////////////////
   // Register bus
   logic        wait_q, wait_d;      // Waitrequest, one wait state
   logic [31:0] rdata_q, rdata_d;    // Read data
   logic        auto_en_q, auto_en_d;  // Automatic acknowledge
   logic        busy_en_q, busy_en_d;  // Busy output enable
   logic        wup_q, wup_d;        // Address wake-up flag
   logic        mode_q, mode_d;      // Serial bus mode
   irq_vec_t    irq_en_q, irq_en_d;  // Interrupt enables

   // Link state read back by software
   bit_cnt_t    cnt_q;
   logic        done_q, ackd_q, cmd_pend_q;
   irq_vec_t    irq_stat_q;
   logic        in_xfer;
   assign in_xfer = (cnt_q != `CNT_IDLE) && (cnt_q < `CNT_ACK_SLOT);

   logic       wr_acc, rd_acc;       // Access completes this edge
   logic [7:0] idx;                  // Word index of the access
   assign wr_acc = write_i & ~wait_q;
   assign rd_acc = read_i & ~wait_q;
   assign idx    = address_i[9:2];
   logic wr_sbi0, wr_ctrl, wr_clr;   // Write strobes per register
   assign wr_sbi0 = wr_acc && (idx == `IDX_SBI0);
   assign wr_ctrl = wr_acc && (idx == `IDX_CTRL);
   assign wr_clr  = wr_acc && (idx == `IDX_IRQ_CLR);
   // Decode, read mux and writable fields
   always_comb begin
      wait_d    = ~((read_i | write_i) & wait_q);
      rdata_d   = rdata_q;
      auto_en_d = auto_en_q;
      busy_en_d = busy_en_q;
      wup_d     = wup_q;
      mode_d    = mode_q;
      irq_en_d  = irq_en_q;
      if ((read_i | write_i) & wait_q) begin
         // Unmapped words read as zero
         rdata_d = 32'h0000_0000;
         case (idx)
            `IDX_SBI0: begin
               rdata_d[`BIT_AUTO_ACK] = auto_en_q;
               rdata_d[`BIT_ACK_DET]  = ackd_q;
               rdata_d[`BIT_BUSY_EN]  = busy_en_q;
               rdata_d[`BIT_ACK_TRIG] = 1'b0;
            end
            `IDX_CTRL: begin
               rdata_d[`BIT_WAKEUP]    = wup_q;
               rdata_d[`BIT_SBUS_MODE] = mode_q;
               rdata_d[`BIT_CMD_TRIG]  = 1'b0;
               rdata_d[`BIT_REL_TRIG]  = 1'b0;
            end
            `IDX_STATUS: begin
               rdata_d[`BIT_DONE]     = done_q;
               rdata_d[`BIT_IN_XFER]  = in_xfer;
               rdata_d[`BIT_CMD_PEND] = cmd_pend_q;
            end
            `IDX_IRQ_STAT: rdata_d[1:0] = irq_stat_q;
            `IDX_IRQ_EN:   rdata_d[1:0] = irq_en_q;
            default:       rdata_d = 32'h0000_0000;
         endcase
      end
      if (wr_sbi0) begin
         // Detected flag is not writable here
         auto_en_d = writedata_i[`BIT_AUTO_ACK];
         busy_en_d = writedata_i[`BIT_BUSY_EN];
      end
      if (wr_ctrl) begin
         wup_d  = writedata_i[`BIT_WAKEUP];
         mode_d = writedata_i[`BIT_SBUS_MODE];
      end
      if (wr_acc && (idx == `IDX_IRQ_EN)) begin
         irq_en_d = writedata_i[1:0];
      end
   end

   // Bus registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wait_q    <= 1'b1;
         rdata_q   <= 32'h0000_0000;
         auto_en_q <= 1'b0;
         busy_en_q <= 1'b0;
         wup_q     <= 1'b0;
         mode_q    <= 1'b0;
         irq_en_q  <= `RST_IRQ;
      end else begin
         wait_q    <= wait_d;
         rdata_q   <= rdata_d;
         auto_en_q <= auto_en_d;
         busy_en_q <= busy_en_d;
         wup_q     <= wup_d;
         mode_q    <= mode_d;
         irq_en_q  <= irq_en_d;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Link control
   bit_cnt_t cnt_d;
   logic     done_d, ackd_d, cmd_pend_d;
   logic     ack_drv_q, ack_drv_d;    // Pulling data low to acknowledge
   logic     ack_arm_q, ack_arm_d;    // One-shot acknowledge pending
   logic     busy_q, busy_d;          // Pulling data low as busy
   logic     addr_q, addr_d;          // First byte after a start
   irq_vec_t irq_stat_d, ev;
   logic     irq_q, irq_d;
   logic     oe_n_q, oe_n_d;
   // Bit counting, acknowledge, busy, triggers and events
   always_comb begin
      cnt_d      = cnt_q;
      done_d     = done_q;
      ackd_d     = ackd_q;
      cmd_pend_d = cmd_pend_q;
      ack_drv_d  = ack_drv_q;
      ack_arm_d  = ack_arm_q;
      busy_d     = busy_q;
      addr_d     = addr_q;
      ev         = `RST_IRQ;
      if (start_det) begin
         cnt_d  = `CNT_IDLE;
         addr_d = 1'b1;
      end else if (scl_rise) begin
         if (cnt_q == `CNT_ACK_SLOT) begin
            // Sample the far end's acknowledge, not our own
            if (!ack_drv_q && !sda_s2_q) begin
               ackd_d      = 1'b1;
               ev[`EV_ACK] = 1'b1;
            end
            cnt_d = `CNT_ACK_CLK;
         end else if (cnt_q != `CNT_ACK_CLK) begin
            cnt_d = cnt_q + 4'h1;
         end
         if (cnt_q == `CNT_IDLE) begin
            // New byte: old results no longer hold
            done_d = 1'b0;
            ackd_d = 1'b0;
         end
         if (cnt_q == `CNT_LAST_DATA) begin
            done_d     = 1'b1;
            cmd_pend_d = 1'b0;
            // With wake-up set only the address byte raises the done event
            ev[`EV_DONE] = ~wup_q | addr_q;
         end
      end else if (scl_fall) begin
         if (cnt_q == `CNT_ACK_CLK) begin
            // Ninth clock over: release acknowledge
            cnt_d     = `CNT_IDLE;
            ack_drv_d = 1'b0;
            ack_arm_d = 1'b0;
            addr_d    = 1'b0;
            busy_d    = busy_en_q & mode_q;
         end else if (!busy_en_q) begin
            busy_d = 1'b0;
         end
      end
      // Drive once the byte is done and the clock is low
      if ((cnt_q == `CNT_ACK_SLOT) && !scl_s2_q &&
          (auto_en_q || ack_arm_q)) begin
         ack_drv_d = 1'b1;
      end
      // Trigger set wins over its own clearing
      if (wr_sbi0 && writedata_i[`BIT_ACK_TRIG]) begin
         ack_arm_d = 1'b1;
      end
      if (wr_ctrl && writedata_i[`BIT_CMD_TRIG] && !in_xfer) begin
         cmd_pend_d = 1'b1;
         cnt_d      = `CNT_IDLE;
      end
      if (wr_ctrl && writedata_i[`BIT_REL_TRIG]) begin
         // Let go of the data line at once
         ack_drv_d = 1'b0;
         ack_arm_d = 1'b0;
         busy_d    = 1'b0;
         cnt_d     = `CNT_IDLE;
      end
      // Sticky events; a new event wins over the clear
      irq_stat_d = irq_stat_q;
      if (wr_clr) begin
         irq_stat_d = irq_stat_q & ~writedata_i[1:0];
      end
      irq_stat_d = irq_stat_d | ev;
      irq_d      = |(irq_stat_q & irq_en_q);
      oe_n_d     = ~(ack_drv_d | busy_d);
   end

   // Link registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_q      <= `CNT_IDLE;
         done_q     <= 1'b0;
         ackd_q     <= 1'b0;
         cmd_pend_q <= 1'b0;
         ack_drv_q  <= 1'b0;
         ack_arm_q  <= 1'b0;
         busy_q     <= 1'b0;
         addr_q     <= 1'b0;
         irq_stat_q <= `RST_IRQ;
         irq_q      <= 1'b0;
         oe_n_q     <= 1'b1;
      end else begin
         cnt_q      <= cnt_d;
         done_q     <= done_d;
         ackd_q     <= ackd_d;
         cmd_pend_q <= cmd_pend_d;
         ack_drv_q  <= ack_drv_d;
         ack_arm_q  <= ack_arm_d;
         busy_q     <= busy_d;
         addr_q     <= addr_d;
         irq_stat_q <= irq_stat_d;
         irq_q      <= irq_d;
         oe_n_q     <= oe_n_d;
      end
   end
   // Data line only ever pulled low
   logic sda_out_q;
   always_ff @(posedge clk_i) begin
      sda_out_q <= 1'b0;
   end
   assign readdata_o    = rdata_q;
   assign waitrequest_o = wait_q;
   assign irq_o         = irq_q;
   assign sda_o         = sda_out_q;
   assign sda_oe_n_o    = oe_n_q;
   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_read_sbi0;
      rd_acc && (idx == `IDX_SBI0);
   endsequence
   sequence s_read_ctrl;
      rd_acc && (idx == `IDX_CTRL);
   endsequence
   a_ack_trig_zero: assert property (
      s_read_sbi0 |-> !readdata_o[`BIT_ACK_TRIG])
      else $error("acknowledge trigger read as one");
   a_cmd_trig_zero: assert property (
      s_read_ctrl |-> !readdata_o[`BIT_CMD_TRIG])
      else $error("command trigger read as one");
   a_rel_trig_zero: assert property (
      s_read_ctrl |-> !readdata_o[`BIT_REL_TRIG])
      else $error("release trigger read as one");
   a_cmd_ignored: assert property (
      wr_ctrl && writedata_i[`BIT_CMD_TRIG] && in_xfer
      && !cmd_pend_q |=> !cmd_pend_q)
      else $error("command trigger taken in transfer");
   a_ackd_no_write: assert property (
      wr_sbi0 && !scl_rise && !start_det |=> $stable(ackd_q))
      else $error("write changed acknowledge flag");
   a_auto_ack_drive: assert property (
      auto_en_q && cnt_q == `CNT_ACK_SLOT && !scl_s2_q
      && !wr_ctrl |=> ##1 !sda_oe_n_o)
      else $error("automatic acknowledge not driven");
   a_ack_detect: assert property (
      scl_rise && cnt_q == `CNT_ACK_SLOT && !ack_drv_q
      && !sda_s2_q |=> ackd_q ##1 irq_stat_q[`EV_ACK])
      else $error("acknowledge not detected");
   a_busy_stop: assert property (
      busy_q && scl_fall && !busy_en_q && cnt_q != `CNT_ACK_CLK
      |=> !busy_q ##1 sda_oe_n_o)
      else $error("busy not stopped on falling edge");
   a_auto_persist: assert property (
      scl_fall && cnt_q == `CNT_ACK_CLK && auto_en_q && !wr_sbi0
      |=> auto_en_q)
      else $error("auto acknowledge enable cleared");
   a_done_valid: assert property (
      cnt_q == `CNT_ACK_SLOT |-> done_q)
      else $error("completion flag low after byte");

endmodule : serial_bus_ack_busy_control
`default_nettype wire

/* File: sbi_far_master.sv */
// Behavioural model of the remote master on the two-wire serial link
`timescale 1ns/100ps
`default_nettype none
module sbi_far_master (
   // Device side of the open drain data line
   input  wire logic dev_oe_n_i,
   input  wire logic dev_sda_i,
   // Resolved link lines
   output logic      scl_o,
   output logic      sda_o
);
   logic m_sda;   // Own drive, 1 means released

   // Pull-up wired AND: a released line reads high, never the last value
   assign sda_o = m_sda & (dev_oe_n_i | dev_sda_i);

   // Idle bus, clock stands still high
   initial begin
      scl_o = 1'b1;
      m_sda = 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////
   // Start, then eight data clocks; clock is left low in the ack slot
   task automatic data8(input logic [7:0] d, input int h);
      #1;   // Step off the device clock's sampling edge
      m_sda = 1'b1;
      #(h/2);
      scl_o = 1'b1;
      #(h);
      m_sda = 1'b0;   // Start: data falls while clock is high
      #(h);
      for (int i = 7; i >= 0; i--) begin
         scl_o = 1'b0;
         #(h/2);
         m_sda = d[i];
         #(h/2);
         scl_o = 1'b1;
         #(h);
      end
      scl_o = 1'b0;
      #(h/2);
      m_sda = 1'b1;
   endtask : data8

   // Ninth clock; low reports whether the line was low at its high phase
   task automatic ack9(input logic m_ack, input int h, output logic low);
      #1;   // Step off the device clock's sampling edge
      m_sda = ~m_ack;
      #(h/2);
      scl_o = 1'b1;
      #(h/2);
      low = ~sda_o;
      #(h/2);
      scl_o = 1'b0;
      #(h/2);
      m_sda = 1'b1;   // Hold time over, let go of the line
   endtask : ack9

   // Single extra clock pulse, used to end a busy period
   task automatic pulse(input int h);
      #1;   // Step off the device clock's sampling edge
      scl_o = 1'b1;
      #(h);
      scl_o = 1'b0;
      #(h);
   endtask : pulse
endmodule : sbi_far_master
`default_nettype wire

/* File: serial_bus_ack_busy_control_tb.sv */
// Register level testbench of the acknowledge and busy control
`timescale 1ns/100ps
`default_nettype none
`include "sbi_consts.svh"
module serial_bus_ack_busy_control_tb;
   logic        clk_i;         // 100 MHz clock
   logic        rst_i;         // Synchronous reset
   logic [9:0]  address_i;     // Byte address
   logic        read_i;        // Read request
   logic        write_i;       // Write request
   logic [31:0] writedata_i;   // Write data
   logic [31:0] readdata_o;    // Read data
   logic        waitrequest_o; // Bus stall
   logic        irq_o;         // Interrupt level
   logic        scl;           // Link clock
   logic        sda;           // Resolved data line
   logic        sda_o;         // Device data drive
   logic        sda_oe_n_o;    // Device drive enable, low active
   logic [31:0] q;             // Read result
   logic        low;           // Line low during ninth clock
   int          miscompares;   // Mismatch count
   int          compares;      // Comparison count

   serial_bus_ack_busy_control dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .address_i(address_i), .read_i(read_i), .write_i(write_i),
      .writedata_i(writedata_i), .readdata_o(readdata_o),
      .waitrequest_o(waitrequest_o), .irq_o(irq_o), .scl_i(scl),
      .sda_i(sda), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o));
   sbi_far_master p_u (.dev_oe_n_i(sda_oe_n_o), .dev_sda_i(sda_o),
      .scl_o(scl), .sda_o(sda));

   // Free running clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   ////////////////////////////////////////////////////////////////////////
   // One bus cycle; holds everything until waitrequest is seen low
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge clk_i);
      address_i   <= {a, 2'b00};
      read_i      <= ~w;
      write_i     <= w;
      writedata_i <= d;
      // No wait limit here; a stuck slave is caught by the watchdog
      do begin
         @(posedge clk_i);
      end while (waitrequest_o !== 1'b0);
      r = readdata_o;
      read_i  <= 1'b0;
      write_i <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(a, 1'b1, d, x);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] r);
      bus(a, 1'b0, 32'h0, r);
   endtask : rd

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc

   // Word compare, four-state exact
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Single place where the run ends
   task automatic wrap_up();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : wrap_up

   // Watchdog, well beyond the few frames of the run
   initial begin
      #300000;
      miscompares++;
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      miscompares = 0;
      compares = 0;
      rst_i = 1'b1;
      address_i = 10'h0;
      read_i = 1'b0;
      write_i = 1'b0;
      writedata_i = 32'h0;
      cyc(4);
      rst_i <= 1'b0;
      // Reset values, unmapped space, read-only and self clearing bits
      rd(`IDX_SBI0, q); chk(q, 32'h0);
      rd(8'h3f, q); chk(q, 32'h0);
      wr(`IDX_SBI0, 32'he); rd(`IDX_SBI0, q); chk(q, 32'ha);
      wr(`IDX_CTRL, 32'h2); rd(`IDX_CTRL, q); chk(q, 32'h0);
      wr(`IDX_CTRL, 32'h1); rd(`IDX_CTRL, q); chk(q, 32'h0);
      rd(`IDX_STATUS, q); chk(q & 32'h4, 32'h4);
      // Automatic acknowledge armed before the byte ends
      wr(`IDX_SBI0, 32'h2);
      p_u.data8(8'ha5, 40);
      rd(`IDX_STATUS, q); chk(q & 32'h5, 32'h1);
      cyc(10); chk({31'h0, sda_oe_n_o}, 32'h0);
      p_u.ack9(1'b0, 40, low); chk({31'h0, low}, 32'h1);
      cyc(10); chk({31'h0, sda_oe_n_o}, 32'h1);
      rd(`IDX_SBI0, q); chk(q, 32'h2);
      // Acknowledge from the far side, interrupt raised, masked, cleared
      wr(`IDX_SBI0, 32'h0);
      wr(`IDX_IRQ_EN, 32'h2);
      p_u.data8(8'h5a, 40);
      cyc(10); chk({31'h0, sda_oe_n_o}, 32'h1);
      p_u.ack9(1'b1, 40, low);
      rd(`IDX_SBI0, q); chk(q, 32'h4);
      cyc(2); chk({31'h0, irq_o}, 32'h1);
      wr(`IDX_IRQ_EN, 32'h0); cyc(2); chk({31'h0, irq_o}, 32'h0);
      wr(`IDX_IRQ_EN, 32'h2); wr(`IDX_IRQ_CLR, 32'h3);
      cyc(2); chk({31'h0, irq_o}, 32'h0);
      rd(`IDX_IRQ_STAT, q); chk(q, 32'h0);
      // One-shot trigger after the byte is complete
      p_u.data8(8'h81, 40);
      cyc(10); chk({31'h0, sda_oe_n_o}, 32'h1);
      wr(`IDX_SBI0, 32'h1);
      rd(`IDX_SBI0, q); chk(q, 32'h0);
      cyc(10); chk({31'h0, sda_oe_n_o}, 32'h0);
      chk({31'h0, sda_o}, 32'h0);
      p_u.ack9(1'b0, 40, low); chk({31'h0, low}, 32'h1);
      // Trigger is spent; enabling late acknowledges on the next clock
      p_u.data8(8'h7e, 40);
      cyc(10); chk({31'h0, sda_oe_n_o}, 32'h1);
      wr(`IDX_SBI0, 32'h2);
      cyc(10); chk({31'h0, sda_oe_n_o}, 32'h0);
      p_u.ack9(1'b0, 40, low);
      // Busy after the acknowledge, slow far side
      wr(`IDX_CTRL, 32'h8);
      wr(`IDX_SBI0, 32'ha);
      p_u.data8(8'hc3, 40);
      p_u.ack9(1'b0, 40, low);
      cyc(10); chk({31'h0, sda_oe_n_o}, 32'h0);
      wr(`IDX_SBI0, 32'h2);
      cyc(10); chk({31'h0, sda_oe_n_o}, 32'h0);
      p_u.pulse(40);
      cyc(10); chk({31'h0, sda_oe_n_o}, 32'h1);
      // Command trigger refused in mid-byte
      wr(`IDX_CTRL, 32'h4);
      wr(`IDX_IRQ_CLR, 32'h3);
      fork
         p_u.data8(8'h3c, 40);
         begin
            cyc(20);
            wr(`IDX_CTRL, 32'h5);
            rd(`IDX_STATUS, q); chk(q & 32'h6, 32'h2);
         end
      join
      p_u.ack9(1'b0, 40, low);
      // Address byte after a start still raises the done event
      rd(`IDX_IRQ_STAT, q); chk(q & 32'h1, 32'h1);
      wrap_up();
   end
endmodule : serial_bus_ack_busy_control_tb
`default_nettype wire
